// >>> dac_dp_defs.svh
`ifndef DAC_DP_DEFS_SVH
`define DAC_DP_DEFS_SVH

// Register offsets.
`define ADDR_DATAPATH_MODE   5'h03
`define ADDR_INPUT_SOURCE    5'h04
`define ADDR_RESYNC_CONTROL  5'h05
`define ADDR_FIXED_LOW       5'h06
`define ADDR_FIXED_HIGH      5'h07
`define ADDR_BYPASS_MASK     5'h08
`define ADDR_TUNING_BYTE0    5'h09
`define ADDR_TUNING_BYTE1    5'h0a
`define ADDR_TUNING_BYTE3    5'h0b
`define ADDR_TUNING_BYTE2    5'h0c
`define ADDR_PHASE_LOW       5'h0d
`define ADDR_PHASE_HIGH      5'h0e

// Reset values.
`define RST_DATAPATH_MODE    8'h80
`define RST_ZERO             8'h00
`define RST_TUNING_BYTE2     8'h40

// Datapath mode fields.
`define BIT_OSC_ENABLE       7
`define BIT_OSC_DOUBLE       6
`define BIT_QUAD_CORR        5
`define COARSE_MSB           4
`define COARSE_LSB           1
`define BIT_SINC_ENABLE      0

// Input source fields.
`define BIT_FOUR_WIRE        7
`define BIT_FIXED_WORD       6
`define BIT_HALF_RATE        5
`define BIT_UPPER_SIDEBAND   3
`define COUNTER_MSB          2
`define COUNTER_LSB          0

// Resync control fields.
`define BIT_DIV_RESYNC       7
`define BIT_ACC_CLEAR        6
`define BIT_COARSE_RESYNC    5
`define FIFO_SYNC_MSB        4
`define FIFO_SYNC_LSB        2

// Fixed-point scaling of the correction words (1024 is unity) and of the inverse-sinc taps (over 16).
`define CORR_SHIFT           10
`define SINC_SHIFT           4

`endif

// >>> dac_dp_pkg.sv
package dac_dp_pkg;

	// One sample for each of the two channels.
	typedef struct packed {
		logic signed [15:0] a;
		logic signed [15:0] b;
	} pair_s;

	// Quadrature correction words from the neighbouring register group.
	typedef struct packed {
		logic [10:0]        gain_a;
		logic [10:0]        gain_b;
		logic signed [9:0]  phase;
	} corr_s;

	// FIFO pointer sync sources.
	typedef enum logic [2:0] {
		SYNC_TX_GATE  = 3'b000,
		SYNC_STROBE   = 3'b001,
		SYNC_MARKER   = 3'b010,
		SYNC_B15      = 3'b011,
		SYNC_A15_ONCE = 3'b100,
		SYNC_SOFTWARE = 3'b101,
		SYNC_OFF      = 3'b110,
		SYNC_ALWAYS   = 3'b111
	} sync_src_e;

	// Internal counter source modes.
	typedef enum logic [2:0] {
		CNT_OFF0 = 3'b000,
		CNT_OFF1 = 3'b001,
		CNT_OFF2 = 3'b010,
		CNT_OFF3 = 3'b011,
		CNT_ALL  = 3'b100,
		CNT_LOW  = 3'b101,
		CNT_MID  = 3'b110,
		CNT_TOP  = 3'b111
	} cnt_mode_e;

endpackage

// >>> dac_datapath_control_regs.sv
`timescale 1ns/1ps
`include "dac_dp_defs.svh"

module dac_datapath_control_regs
	import dac_dp_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst,
	// Decoded register port from the serial configuration interface.
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [4:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	output logic             four_wire_port_select,
	// Device pins.
	input  wire logic        phase_strobe,
	input  wire logic        tx_gate,
	input  wire logic        chan_b_marker,
	input  wire logic [15:0] port_a_bus,
	input  wire logic [15:0] port_b_bus,
	// Correction words held elsewhere.
	input  wire corr_s       corr,
	// Datapath results and sync pulses.
	output pair_s            dac_out,
	output logic             divider_init,
	output logic             fifo_ptr_init
);

	logic [7:0]  datapath_mode_config;
	logic [7:0]  input_source_config;
	logic [7:0]  resync_control;
	logic [7:0]  fixed_word_low;
	logic [7:0]  fixed_word_high;
	logic [7:0]  factory_bypass_mask;
	logic [7:0]  osc_tuning_byte0;
	logic [7:0]  osc_tuning_byte1;
	logic [7:0]  osc_tuning_byte2;
	logic [7:0]  osc_tuning_byte3;
	logic [7:0]  osc_phase_offset_low;
	logic [7:0]  osc_phase_offset_high;

	logic [3:0]  coarse_mix_select;
	cnt_mode_e   cnt_mode;
	sync_src_e   sync_src;
	logic [31:0] tuning_word;
	logic [15:0] phase_offset;
	logic [15:0] fixed_word;
	logic        strobe_d;
	logic        strobe_rise;
	logic        sync_d;
	logic        sync_level;
	logic        a15_armed;
	logic        sw_sync;
	logic [15:0] counter;
	logic        half_phase;
	logic [15:0] half_hold;
	logic [31:0] phase_acc;
	logic [15:0] osc_phase;
	logic [1:0]  coarse_idx;
	pair_s       next_src;
	pair_s       src_q;
	pair_s       next_mix;
	pair_s       mix_q;
	pair_s       next_corr;
	pair_s       corr_q;
	pair_s       sinc_x1;
	pair_s       sinc_x2;
	pair_s       next_sinc;
	pair_s       sinc_q;
	pair_s       next_coarse;

	// Clamp a wide signed value into a 16-bit sample.
	function automatic logic signed [15:0] sat16(
		input logic signed [29:0] v
	);
		if (v > 30'sd32767) begin
			sat16 = 16'sh7fff;
		end else if (v < -30'sd32768) begin
			sat16 = 16'sh8000;
		end else begin
			sat16 = v[15:0];
		end
	endfunction

	// Negate without wrapping the most negative sample.
	function automatic logic signed [15:0] neg16(
		input logic signed [15:0] v
	);
		neg16 = sat16(-{{14{v[15]}}, v});
	endfunction

	// Field views of the registers.
	assign coarse_mix_select = datapath_mode_config[`COARSE_MSB:`COARSE_LSB];
	assign cnt_mode    = cnt_mode_e'(input_source_config[`COUNTER_MSB:
		`COUNTER_LSB]);
	assign sync_src    = sync_src_e'(resync_control[`FIFO_SYNC_MSB:
		`FIFO_SYNC_LSB]);
	assign fixed_word  = {fixed_word_high, fixed_word_low};
	assign tuning_word = {osc_tuning_byte3, osc_tuning_byte2,
		osc_tuning_byte1, osc_tuning_byte0};
	assign phase_offset = {osc_phase_offset_high,
		osc_phase_offset_low};
	assign strobe_rise = phase_strobe & ~strobe_d;

	// Register writes; every register returns to its default on reset.
	always_ff @(posedge clk) begin
		if (rst) begin
			datapath_mode_config  <= `RST_DATAPATH_MODE;
			input_source_config   <= `RST_ZERO;
			resync_control        <= `RST_ZERO;
			fixed_word_low        <= `RST_ZERO;
			fixed_word_high       <= `RST_ZERO;
			factory_bypass_mask   <= `RST_ZERO;
			osc_tuning_byte0      <= `RST_ZERO;
			osc_tuning_byte1      <= `RST_ZERO;
			osc_tuning_byte2      <= `RST_TUNING_BYTE2;
			osc_tuning_byte3      <= `RST_ZERO;
			osc_phase_offset_low  <= `RST_ZERO;
			osc_phase_offset_high <= `RST_ZERO;
		end else if (reg_wr) begin
			if (reg_addr == `ADDR_DATAPATH_MODE) begin
				datapath_mode_config <= reg_wdata;
			end else if (reg_addr == `ADDR_INPUT_SOURCE) begin
				input_source_config <= reg_wdata;
			end else if (reg_addr == `ADDR_RESYNC_CONTROL) begin
				resync_control <= reg_wdata;
			end else if (reg_addr == `ADDR_FIXED_LOW) begin
				fixed_word_low <= reg_wdata;
			end else if (reg_addr == `ADDR_FIXED_HIGH) begin
				fixed_word_high <= reg_wdata;
			end else if (reg_addr == `ADDR_BYPASS_MASK) begin
				factory_bypass_mask <= reg_wdata;
			end else if (reg_addr == `ADDR_TUNING_BYTE0) begin
				osc_tuning_byte0 <= reg_wdata;
			end else if (reg_addr == `ADDR_TUNING_BYTE1) begin
				osc_tuning_byte1 <= reg_wdata;
			end else if (reg_addr == `ADDR_TUNING_BYTE2) begin
				osc_tuning_byte2 <= reg_wdata;
			end else if (reg_addr == `ADDR_TUNING_BYTE3) begin
				osc_tuning_byte3 <= reg_wdata;
			end else if (reg_addr == `ADDR_PHASE_LOW) begin
				osc_phase_offset_low <= reg_wdata;
			end else if (reg_addr == `ADDR_PHASE_HIGH) begin
				osc_phase_offset_high <= reg_wdata;
			end
		end
	end

	// Register reads; unmapped addresses read as zero.
	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata <= `RST_ZERO;
		end else if (reg_rd) begin
			if (reg_addr == `ADDR_DATAPATH_MODE) begin
				reg_rdata <= datapath_mode_config;
			end else if (reg_addr == `ADDR_INPUT_SOURCE) begin
				reg_rdata <= input_source_config;
			end else if (reg_addr == `ADDR_RESYNC_CONTROL) begin
				reg_rdata <= resync_control;
			end else if (reg_addr == `ADDR_FIXED_LOW) begin
				reg_rdata <= fixed_word_low;
			end else if (reg_addr == `ADDR_FIXED_HIGH) begin
				reg_rdata <= fixed_word_high;
			end else if (reg_addr == `ADDR_BYPASS_MASK) begin
				reg_rdata <= factory_bypass_mask;
			end else if (reg_addr == `ADDR_TUNING_BYTE0) begin
				reg_rdata <= osc_tuning_byte0;
			end else if (reg_addr == `ADDR_TUNING_BYTE1) begin
				reg_rdata <= osc_tuning_byte1;
			end else if (reg_addr == `ADDR_TUNING_BYTE2) begin
				reg_rdata <= osc_tuning_byte2;
			end else if (reg_addr == `ADDR_TUNING_BYTE3) begin
				reg_rdata <= osc_tuning_byte3;
			end else if (reg_addr == `ADDR_PHASE_LOW) begin
				reg_rdata <= osc_phase_offset_low;
			end else if (reg_addr == `ADDR_PHASE_HIGH) begin
				reg_rdata <= osc_phase_offset_high;
			end else begin
				reg_rdata <= `RST_ZERO;
			end
		end
	end

	// Serial port pin mode follows the four-wire bit.
	always_ff @(posedge clk) begin
		if (rst) begin
			four_wire_port_select <= 1'b0;
		end else begin
			four_wire_port_select <=
				input_source_config[`BIT_FOUR_WIRE];
		end
	end

	// Phase strobe edge detection and divider restart pulse.
	always_ff @(posedge clk) begin
		if (rst) begin
			strobe_d     <= 1'b0;
			divider_init <= 1'b0;
		end else begin
			strobe_d     <= phase_strobe;
			divider_init <= strobe_rise &
				resync_control[`BIT_DIV_RESYNC];
		end
	end

	// A software sync is a resync write that selects the software source.
	assign sw_sync = reg_wr && (reg_addr == `ADDR_RESYNC_CONTROL) &&
		(reg_wdata[`FIFO_SYNC_MSB:`FIFO_SYNC_LSB] == SYNC_SOFTWARE);

	// Pick the level of the chosen FIFO sync source.
	always_comb begin
		case (sync_src)
			SYNC_TX_GATE:  sync_level = tx_gate;
			SYNC_STROBE:   sync_level = phase_strobe;
			SYNC_MARKER:   sync_level = chan_b_marker;
			SYNC_B15:      sync_level = port_b_bus[15];
			SYNC_A15_ONCE: sync_level = port_a_bus[15] & a15_armed;
			default:       sync_level = 1'b0;
		endcase
	end

	// FIFO pointer initialisation on a rise of the chosen source.
	always_ff @(posedge clk) begin
		if (rst) begin
			sync_d        <= 1'b0;
			a15_armed     <= 1'b1;
			fifo_ptr_init <= 1'b0;
		end else begin
			sync_d <= sync_level;
			if (sync_src == SYNC_A15_ONCE && sync_level && !sync_d) begin
				a15_armed <= 1'b0;
			end else if (sync_src != SYNC_A15_ONCE) begin
				a15_armed <= 1'b1;
			end
			if (sw_sync || sync_src == SYNC_ALWAYS) begin
				fifo_ptr_init <= 1'b1;
			end else if (sync_src == SYNC_SOFTWARE) begin
				fifo_ptr_init <= 1'b0;
			end else begin
				fifo_ptr_init <= sync_level & ~sync_d;
			end
		end
	end

	// Free-running test counter and half-rate capture phase.
	always_ff @(posedge clk) begin
		if (rst) begin
			counter    <= 16'h0000;
			half_phase <= 1'b0;
			half_hold  <= 16'h0000;
		end else begin
			counter    <= counter + 16'h0001;
			half_phase <= ~half_phase;
			if (!half_phase) begin
				half_hold <= port_b_bus;
			end
		end
	end

	// Input source selection and sideband inversion.
	always_comb begin
		next_src.a = port_a_bus;
		next_src.b = port_b_bus;
		if (input_source_config[`BIT_HALF_RATE]) begin
			next_src.a = half_phase ? half_hold : port_a_bus;
			next_src.b = 16'h0000;
		end
		case (cnt_mode)
			CNT_ALL: begin
				next_src.a = counter;
				next_src.b = counter;
			end
			CNT_LOW: begin
				next_src.a = {9'h000, counter[6:0]};
				next_src.b = {9'h000, counter[6:0]};
			end
			CNT_MID: begin
				next_src.a = {5'h00, counter[4:0], 6'h00};
				next_src.b = {5'h00, counter[4:0], 6'h00};
			end
			CNT_TOP: begin
				next_src.a = {counter[4:0], 11'h000};
				next_src.b = {counter[4:0], 11'h000};
			end
			default: begin
			end
		endcase
		if (input_source_config[`BIT_FIXED_WORD]) begin
			next_src.a = fixed_word;
			next_src.b = fixed_word;
		end
		if (input_source_config[`BIT_UPPER_SIDEBAND]) begin
			next_src.b = neg16(next_src.b);
		end
	end

	// Source stage register.
	always_ff @(posedge clk) begin
		if (rst) begin
			src_q <= '0;
		end else begin
			src_q <= next_src;
		end
	end

	// Oscillator phase accumulator, cleared by a qualified strobe rise.
	always_ff @(posedge clk) begin
		if (rst) begin
			phase_acc <= 32'h0000_0000;
		end else if (strobe_rise && resync_control[`BIT_ACC_CLEAR]) begin
			phase_acc <= 32'h0000_0000;
		end else begin
			phase_acc <= phase_acc + tuning_word;
		end
	end

	assign osc_phase = phase_acc[31:16] + phase_offset;

	// Quadrant rotation mixer with optional doubling.
	always_comb begin
		next_mix = src_q;
		if (datapath_mode_config[`BIT_OSC_ENABLE]) begin
			case (osc_phase[15:14])
				2'b01: begin
					next_mix.a = neg16(src_q.b);
					next_mix.b = src_q.a;
				end
				2'b10: begin
					next_mix.a = neg16(src_q.a);
					next_mix.b = neg16(src_q.b);
				end
				2'b11: begin
					next_mix.a = src_q.b;
					next_mix.b = neg16(src_q.a);
				end
				default: begin
				end
			endcase
			if (datapath_mode_config[`BIT_OSC_DOUBLE]) begin
				next_mix.a = sat16({{13{next_mix.a[15]}}, next_mix.a, 1'b0});
				next_mix.b = sat16({{13{next_mix.b[15]}}, next_mix.b, 1'b0});
			end
		end
	end

	// Mixer stage register.
	always_ff @(posedge clk) begin
		if (rst) begin
			mix_q <= '0;
		end else begin
			mix_q <= next_mix;
		end
	end

	// Quadrature gain and phase correction.
	always_comb begin
		logic signed [29:0] pa;
		logic signed [29:0] pb;
		pa = 30'(mix_q.a * $signed({1'b0, corr.gain_a}));
		pb = 30'(mix_q.b * $signed({1'b0, corr.gain_b})) +
			30'(mix_q.a * corr.phase);
		next_corr = mix_q;
		if (datapath_mode_config[`BIT_QUAD_CORR]) begin
			next_corr.a = sat16(pa >>> `CORR_SHIFT);
			next_corr.b = sat16(pb >>> `CORR_SHIFT);
		end
	end

	// Correction stage register and filter history.
	always_ff @(posedge clk) begin
		if (rst) begin
			corr_q  <= '0;
			sinc_x1 <= '0;
			sinc_x2 <= '0;
		end else begin
			corr_q  <= next_corr;
			sinc_x1 <= corr_q;
			sinc_x2 <= sinc_x1;
		end
	end

	// Inverse-sinc taps -1, 18, -1 over 16.
	always_comb begin
		logic signed [29:0] fa;
		logic signed [29:0] fb;
		fa = 30'(sinc_x1.a) * 30'sd18 - 30'(corr_q.a) - 30'(sinc_x2.a);
		fb = 30'(sinc_x1.b) * 30'sd18 - 30'(corr_q.b) - 30'(sinc_x2.b);
		next_sinc = sinc_x1;
		if (datapath_mode_config[`BIT_SINC_ENABLE]) begin
			next_sinc.a = sat16(fa >>> `SINC_SHIFT);
			next_sinc.b = sat16(fb >>> `SINC_SHIFT);
		end
	end

	// Filter stage register.
	always_ff @(posedge clk) begin
		if (rst) begin
			sinc_q <= '0;
		end else begin
			sinc_q <= next_sinc;
		end
	end

	// Coarse mixer sequence position, restarted by a qualified strobe.
	always_ff @(posedge clk) begin
		if (rst) begin
			coarse_idx <= 2'b00;
		end else if (strobe_rise &&
			resync_control[`BIT_COARSE_RESYNC]) begin
			coarse_idx <= 2'b00;
		end else begin
			coarse_idx <= coarse_idx + 2'b01;
		end
	end

	// Coarse mixer sign and swap sequences.
	always_comb begin
		next_coarse = sinc_q;
		case (coarse_mix_select[3:2])
			2'b01: begin
				if (coarse_idx[0] == coarse_mix_select[1]) begin
					next_coarse.a = neg16(sinc_q.a);
				end
				if (coarse_idx[0] == coarse_mix_select[0]) begin
					next_coarse.b = neg16(sinc_q.b);
				end
			end
			2'b10: begin
				case (coarse_idx)
					2'b01: begin
						next_coarse.a = neg16(sinc_q.b);
						next_coarse.b = sinc_q.a;
					end
					2'b10: begin
						next_coarse.a = neg16(sinc_q.a);
						next_coarse.b = neg16(sinc_q.b);
					end
					2'b11: begin
						next_coarse.a = sinc_q.b;
						next_coarse.b = neg16(sinc_q.a);
					end
					default: begin
					end
				endcase
			end
			2'b11: begin
				case (coarse_idx)
					2'b01: begin
						next_coarse.a = sinc_q.b;
						next_coarse.b = neg16(sinc_q.a);
					end
					2'b10: begin
						next_coarse.a = neg16(sinc_q.a);
						next_coarse.b = neg16(sinc_q.b);
					end
					2'b11: begin
						next_coarse.a = neg16(sinc_q.b);
						next_coarse.b = sinc_q.a;
					end
					default: begin
					end
				endcase
			end
			default: begin
			end
		endcase
		if (coarse_mix_select[3]) begin
			if (coarse_mix_select[1]) begin
				next_coarse.a = neg16(next_coarse.a);
			end
			if (coarse_mix_select[0]) begin
				next_coarse.b = neg16(next_coarse.b);
			end
		end
	end

	// Output register.
	always_ff @(posedge clk) begin
		if (rst) begin
			dac_out <= '0;
		end else begin
			dac_out <= next_coarse;
		end
	end

endmodule

// >>> dac_datapath_control_regs_assertions.sv
`timescale 1ns/1ps

module dac_ctl_checker (
	// Clock and reset.
	input wire logic       clk,
	input wire logic       rst,
	// Register port.
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [4:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// Pins and pulses.
	input wire logic       four_wire_port_select,
	input wire logic       phase_strobe,
	input wire logic       divider_init,
	input wire logic       fifo_ptr_init
);
	logic [7:0] sync_ctl;
	logic       wr_sync;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// Shadow of the resync control byte qualifies the expected pulses.
	assign wr_sync = reg_wr && reg_addr == 5'h05;
	always_ff @(posedge clk) begin
		if (rst)
			sync_ctl <= 8'h00;
		else if (wr_sync)
			sync_ctl <= reg_wdata;
	end

	a_rd_unmapped: assert property (
		reg_rd && (reg_addr < 5'h03 || reg_addr > 5'h0e) |=> reg_rdata == 8'h00)
		else $error("Unmapped read returned nonzero data.");
	a_rdata_holds: assert property (
		!reg_rd |=> $stable(reg_rdata))
		else $error("Read data moved without a read.");
	a_wr_readback: assert property (
		(reg_wr && reg_addr inside {[5'h03:5'h0e]}) ##1 !reg_wr ##1
		(reg_rd && reg_addr == $past(reg_addr, 2))
		|=> reg_rdata == $past(reg_wdata, 3))
		else $error("Read after write returned wrong data.");
	a_four_wire_copy: assert property (
		(reg_wr && reg_addr == 5'h04) ##1 !(reg_wr && reg_addr == 5'h04)
		|=> four_wire_port_select == $past(reg_wdata[7], 2))
		else $error("Four-wire select does not follow its bit.");
	a_div_on_rise: assert property (
		phase_strobe && !$past(phase_strobe) && sync_ctl[7] |=> divider_init)
		else $error("Divider restart missing after strobe rise.");
	a_div_cause: assert property (
		divider_init |-> $past(phase_strobe) && !$past(phase_strobe, 2)
		&& $past(sync_ctl[7]))
		else $error("Divider restart without enabled strobe rise.");
	a_fifo_strobe: assert property (
		sync_ctl[4:2] == 3'b001 && phase_strobe && !$past(phase_strobe)
		|=> fifo_ptr_init)
		else $error("FIFO init missing after strobe rise.");
	a_fifo_always: assert property (
		sync_ctl[4:2] == 3'b111 |=> fifo_ptr_init)
		else $error("FIFO init low with source always on.");
	a_fifo_off: assert property (
		sync_ctl[4:2] == 3'b110 && $past(sync_ctl[4:2]) == 3'b110
		|-> !fifo_ptr_init)
		else $error("FIFO init high with source disabled.");
	a_soft_sync: assert property (
		wr_sync && reg_wdata[4:2] == 3'b101 |-> ##[1:2] fifo_ptr_init)
		else $error("Software sync write gave no FIFO init.");
endmodule

bind dac_datapath_control_regs dac_ctl_checker chk_u (.clk(clk), .rst(rst),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.four_wire_port_select(four_wire_port_select),
	.phase_strobe(phase_strobe), .divider_init(divider_init),
	.fifo_ptr_init(fifo_ptr_init));

// >>> host_model.sv
`timescale 1ns/1ps

module host_model (
	// Clock.
	input wire logic       clk,
	// Register port towards the device.
	output logic           reg_wr,
	output logic           reg_rd,
	output logic     [4:0] reg_addr,
	output logic     [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	// Port idles with both strobes low.
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 5'h00;
		reg_wdata = 8'h00;
	end

	// One write; the bypass mask is only ever given zero.
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= (a == 5'h08) ? 8'h00 : d;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
		#1;
	endtask

	// One read; data is taken after the edge that sampled the strobe.
	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata;
	endtask
endmodule

// >>> dac_datapath_control_regs_test.sv
`timescale 1ns/1ps

module dac_datapath_control_regs_test
	import dac_dp_pkg::*;
();
	logic        clk;
	logic        rst;
	logic        reg_wr;
	logic        reg_rd;
	logic [4:0]  reg_addr;
	logic [7:0]  reg_wdata;
	logic [7:0]  reg_rdata;
	logic        four_wire_port_select;
	logic        phase_strobe;
	logic        tx_gate;
	logic        chan_b_marker;
	logic [15:0] port_a_bus;
	logic [15:0] port_b_bus;
	corr_s       corr;
	pair_s       dac_out;
	logic        divider_init;
	logic        fifo_ptr_init;
	logic [7:0]  d;
	logic        f;
	logic [15:0] sa [8];
	logic [15:0] sb [8];
	int          failures = 0;
	int          total_checks = 0;
	int          cycles = 0;
	localparam logic [3:0] neg_a [4] = '{4'h0, 4'h5, 4'h6, 4'hc};
	localparam logic [3:0] neg_b [4] = '{4'h0, 4'h5, 4'hc, 4'h6};
	localparam logic [15:0] cnt_mask [4] = '{16'hffff, 16'h007f,
		16'h07c0, 16'hf800};
	localparam logic [15:0] cnt_step [4] = '{16'h0001, 16'h0001,
		16'h0040, 16'h0800};

	dac_datapath_control_regs dut_u (.clk(clk), .rst(rst), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .four_wire_port_select(four_wire_port_select),
		.phase_strobe(phase_strobe), .tx_gate(tx_gate),
		.chan_b_marker(chan_b_marker), .port_a_bus(port_a_bus),
		.port_b_bus(port_b_bus), .corr(corr), .dac_out(dac_out),
		.divider_init(divider_init), .fifo_ptr_init(fifo_ptr_init));
	host_model host_u (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

	// Free-running 250 MHz clock and a hang guard.
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			conclude();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("checks=%0d failures=%0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Value a register reads after reset, or after the pattern pass.
	function automatic logic [7:0] expect_reg(input int a, input logic pat);
		if (a < 3 || a > 14 || (pat && a == 8))
			return 8'h00;
		if (pat)
			return {a[3:0], ~a[3:0]};
		return (a == 3) ? 8'h80 : ((a == 12) ? 8'h40 : 8'h00);
	endfunction

	// True when the captured samples follow the coarse sign sequence.
	function automatic logic coarse_ok(input logic [3:0] m);
		logic [3:0] na;
		logic [3:0] nb;
		logic       ok;
		logic       hit;
		na = neg_a[m[3:2]] ^ {4{m[1] && m[3:2] != 2'b00}};
		nb = neg_b[m[3:2]] ^ {4{m[0] && m[3:2] != 2'b00}};
		ok = 1'b0;
		for (int k = 0; k < 4; k++) begin
			hit = 1'b1;
			for (int i = 0; i < 8; i++) begin
				if (sa[i] !== (na[(i + k) % 4] ? 16'hedcc : 16'h1234))
					hit = 1'b0;
				if (sb[i] !== (nb[(i + k) % 4] ? 16'hedcc : 16'h1234))
					hit = 1'b0;
			end
			ok = ok | hit;
		end
		return ok;
	endfunction

	// Raises every sync source together, then checks both pulses.
	task automatic rise_all(input logic ef, input logic ed);
		@(posedge clk);
		{phase_strobe, tx_gate, chan_b_marker} <= 3'b111;
		port_a_bus[15] <= 1'b1;
		port_b_bus[15] <= 1'b1;
		@(posedge clk);
		{phase_strobe, tx_gate, chan_b_marker} <= 3'b000;
		port_a_bus[15] <= 1'b0;
		port_b_bus[15] <= 1'b0;
		#1;
		check(fifo_ptr_init, ef);
		check(divider_init, ed);
		@(posedge clk);
		#1;
		check(divider_init, 1'b0);
	endtask

	// Main sequence.
	initial begin
		rst = 1'b1;
		{phase_strobe, tx_gate, chan_b_marker} = 3'b000;
		port_a_bus = 16'h0000;
		port_b_bus = 16'h0000;
		corr = {11'h400, 11'h400, 10'h000};
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		for (int a = 0; a < 32; a++) begin
			host_u.rd(a[4:0], d);
			check(d, expect_reg(a, 1'b0));
		end
		for (int a = 0; a < 32; a++)
			host_u.wr(a[4:0], {a[3:0], ~a[3:0]});
		for (int a = 0; a < 32; a++) begin
			host_u.rd(a[4:0], d);
			check(d, expect_reg(a, 1'b1));
		end
		$display("registers test done");
		for (int v = 0; v < 2; v++) begin
			host_u.wr(5'h04, {v[0], 7'h00});
			@(posedge clk);
			#1;
			check(four_wire_port_select, v[0]);
		end
		host_u.wr(5'h03, 8'h00);
		host_u.wr(5'h06, 8'h34);
		host_u.wr(5'h07, 8'h12);
		host_u.rd(5'h07, d);
		check(d, 8'h12);
		host_u.wr(5'h04, 8'h40);
		repeat (8) @(posedge clk);
		#1;
		check(dac_out, {16'h1234, 16'h1234});
		host_u.wr(5'h04, 8'h48);
		repeat (8) @(posedge clk);
		#1;
		check(dac_out, {16'h1234, 16'hedcc});
		host_u.wr(5'h04, 8'h40);
		for (int m = 0; m < 16; m++) begin
			host_u.wr(5'h03, {3'b000, m[3:0], 1'b0});
			repeat (8) @(posedge clk);
			for (int i = 0; i < 8; i++) begin
				@(posedge clk);
				#1;
				sa[i] = dac_out.a;
				sb[i] = dac_out.b;
			end
			check(coarse_ok(m[3:0]), 1'b1);
		end
		// Counter source: both channels equal, field confined, steps by the field's lowest bit.
		host_u.wr(5'h03, 8'h00);
		for (int c = 4; c < 8; c++) begin
			host_u.wr(5'h04, {5'h00, c[2:0]});
			repeat (8) @(posedge clk);
			#1;
			sa[0] = dac_out.a;
			@(posedge clk);
			#1;
			check(dac_out.b, dac_out.a);
			check(dac_out.a & ~cnt_mask[c - 4], 16'h0000);
			sb[0] = dac_out.a - sa[0];
			check(sb[0] & cnt_mask[c - 4], cnt_step[c - 4]);
		end
		// Half-rate input: channel A alternates between the two buses.
		@(posedge clk);
		port_a_bus <= 16'h1111;
		port_b_bus <= 16'h2222;
		host_u.wr(5'h04, 8'h20);
		repeat (8) @(posedge clk);
		#1;
		sa[0] = dac_out.a;
		@(posedge clk);
		#1;
		check(dac_out.a ^ sa[0], 16'h3333);
		check(dac_out.b, 16'h0000);
		// Strobe restarts the coarse sequence and clears the accumulator.
		host_u.wr(5'h04, 8'h40);
		for (int a = 9; a < 13; a++)
			host_u.wr(a[4:0], 8'h00);
		host_u.wr(5'h0e, 8'h80);
		host_u.wr(5'h03, 8'h08);
		host_u.wr(5'h05, 8'h60);
		rise_all(1'b1, 1'b0);
		check(dac_out, {16'hedcc, 16'hedcc});
		@(posedge clk);
		#1;
		check(dac_out, {16'h1234, 16'h1234});
		host_u.wr(5'h03, 8'hc0);
		repeat (8) @(posedge clk);
		#1;
		check(dac_out, {16'hdb98, 16'hdb98});
		@(posedge clk);
		corr <= {11'h200, 11'h400, 10'h000};
		host_u.wr(5'h03, 8'h20);
		repeat (8) @(posedge clk);
		#1;
		check(dac_out, {16'h091a, 16'h1234});
		$display("datapath test done");
		host_u.wr(5'h05, 8'h98);
		rise_all(1'b0, 1'b1);
		for (int c = 0; c < 8; c++) begin
			host_u.wr(5'h05, {3'b000, c[2:0], 2'b00});
			f = fifo_ptr_init;
			@(posedge clk);
			#1;
			f = f | fifo_ptr_init;
			check(f, c == 5 || c == 7);
			rise_all(c != 5 && c != 6, 1'b0);
			if (c == 4)
				rise_all(1'b0, 1'b0);
		end
		$display("sync test done");
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		host_u.rd(5'h03, d);
		check(d, 8'h80);
		host_u.rd(5'h0c, d);
		check(d, 8'h40);
		$display("reset test done");
		conclude();
	end
endmodule
